//--- hw/mms_pkg.sv
// shared constants for the memory map size and programming mode select block
package mms_pkg;

    // register reset values
    localparam logic [7:0] MEM_SIZE_RESET = 8'hcf;
    localparam logic [7:0] XRAM_SIZE_RESET = 8'h0c;

    // memory size select codes
    localparam logic [7:0] MEM_CODE_16K = 8'hc4;
    localparam logic [7:0] MEM_CODE_24K = 8'hc6;
    localparam logic [7:0] MEM_CODE_32K = 8'hc8;
    localparam logic [7:0] MEM_CODE_48K = 8'hcc;
    localparam logic [7:0] MEM_CODE_60K = 8'hcf;

    // rom sizes in kilobytes
    localparam logic [5:0] ROM_KB_16 = 6'h10;
    localparam logic [5:0] ROM_KB_24 = 6'h18;
    localparam logic [5:0] ROM_KB_32 = 6'h20;
    localparam logic [5:0] ROM_KB_48 = 6'h30;
    localparam logic [5:0] ROM_KB_60 = 6'h3c;

    // expansion ram select codes and size
    localparam logic [7:0] XRAM_CODE_NONE = 8'h0c;
    localparam logic [7:0] XRAM_CODE_1K = 8'h0a;
    localparam logic [10:0] XRAM_BYTES_1K = 11'h400;
    localparam logic [10:0] XRAM_BYTES_NONE = 11'h000;

    // programming voltage pulse counts per mode
    localparam logic [3:0] PULSES_CSI = 4'h0;
    localparam logic [3:0] PULSES_CSI_SHAKE = 4'h3;
    localparam logic [3:0] PULSES_UART = 4'h8;
    localparam logic [3:0] PULSES_PORT = 4'hc;
    localparam logic [3:0] PULSE_COUNT_MAX = 4'hf;

    // communication modes, one-hot
    typedef enum logic [4:0] {
        MMS_MODE_NONE = 5'h01,
        MMS_MODE_CSI = 5'h02,
        MMS_MODE_CSI_SHAKE = 5'h04,
        MMS_MODE_UART = 5'h08,
        MMS_MODE_PORT = 5'h10
    } mms_mode_t;

    // pulse decoder states, one-hot
    typedef enum logic [3:0] {
        MMS_ST_IDLE = 4'h1,
        MMS_ST_COUNT = 4'h2,
        MMS_ST_DONE = 4'h4,
        MMS_ST_BAD = 4'h8
    } mms_state_t;

endpackage

//--- hw/mms_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module mms_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic d,
    output logic q
);
    logic meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

//--- hw/mms_top.sv
// memory map size registers and programming mode decoder
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - reset loads the memory size select register with cfh, the full rom map.
// - software writes the memory size select register with one 8-bit data write.
// - the visible rom size follows the memory size select register, 16 kb up to 60 kb.
// - code c4h gives 16 kb, c6h 24 kb, c8h 32 kb, cch 48 kb and cfh 60 kb.
// - reset loads the expansion ram size select register with 0ch, no expansion ram.
// - software writes the expansion ram size select register with one 8-bit data write.
// - code 0ch maps no expansion ram and code 0ah maps 1,024 bytes.
// - the count of programming voltage pulses picks the mode: 0, 3, 8 or 12.
// - in port-emulated mode software toggles port pins and no serial hardware runs.
// - in programming mode every pin not used for the link stays in its reset state.
module mms_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // cpu data write port
    input wire logic mem_size_wr,
    input wire logic xram_size_wr,
    input wire logic [7:0] wr_data,
    // register readback
    output logic [7:0] memory_size_select,
    output logic [7:0] expansion_ram_size_select,
    // resulting map
    output logic [5:0] rom_size_kb,
    output logic [10:0] xram_size_bytes,
    output logic xram_enable,
    // programming voltage pin, pulse train ends at transfer_start
    input wire logic prog_voltage_pin,
    input wire logic transfer_start,
    // decoded programming mode
    output logic prog_mode_active,
    output logic prog_mode_valid,
    output logic prog_mode_error,
    output logic clocked_serial_channel_en,
    output logic handshake_line_en,
    output logic async_serial_channel_zero_en,
    output logic port_emulated_en,
    output logic hold_other_pins_reset
);

    ////////////////////////////////////////////////////////////////////////////
    // size registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_size_select <= mms_pkg::MEM_SIZE_RESET;
        end else if (mem_size_wr) begin
            memory_size_select <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expansion_ram_size_select <= mms_pkg::XRAM_SIZE_RESET;
        end else if (xram_size_wr) begin
            expansion_ram_size_select <= wr_data;
        end
    end

    // unlisted codes fall back to the full map so fetches never vanish
    function automatic logic [5:0] rom_kb(input logic [7:0] code);
        unique case (code)
            mms_pkg::MEM_CODE_16K: rom_kb = mms_pkg::ROM_KB_16;
            mms_pkg::MEM_CODE_24K: rom_kb = mms_pkg::ROM_KB_24;
            mms_pkg::MEM_CODE_32K: rom_kb = mms_pkg::ROM_KB_32;
            mms_pkg::MEM_CODE_48K: rom_kb = mms_pkg::ROM_KB_48;
            default: rom_kb = mms_pkg::ROM_KB_60;
        endcase
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_size_kb <= mms_pkg::ROM_KB_60;
        end else begin
            rom_size_kb <= rom_kb(memory_size_select);
        end
    end

    // 0ch and any unlisted code map nothing
    function automatic logic [10:0] xram_bytes(input logic [7:0] code);
        if (code == mms_pkg::XRAM_CODE_1K) begin
            xram_bytes = mms_pkg::XRAM_BYTES_1K;
        end else begin
            xram_bytes = mms_pkg::XRAM_BYTES_NONE;
        end
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xram_size_bytes <= mms_pkg::XRAM_BYTES_NONE;
        end else begin
            xram_size_bytes <= xram_bytes(expansion_ram_size_select);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xram_enable <= 1'b0;
        end else begin
            xram_enable <= (xram_bytes(expansion_ram_size_select) != mms_pkg::XRAM_BYTES_NONE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // programming mode pulse decoder

    logic vpp_s;
    logic start_s;
    logic vpp_prev_reg;
    logic vpp_rise;
    logic [3:0] pulse_cnt_reg;
    mms_pkg::mms_state_t state_reg;
    mms_pkg::mms_mode_t mode_reg;

    mms_sync u_sync_vpp (
        .clk(clk),
        .rst_n(rst_n),
        .d(prog_voltage_pin),
        .q(vpp_s)
    );

    mms_sync u_sync_start (
        .clk(clk),
        .rst_n(rst_n),
        .d(transfer_start),
        .q(start_s)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vpp_prev_reg <= 1'b0;
        end else begin
            vpp_prev_reg <= vpp_s;
        end
    end

    // one strobe per synchronised rising edge; levels under two clocks are not guaranteed
    assign vpp_rise = vpp_s && !vpp_prev_reg;

    // entry has been seen once the decoder leaves idle
    function automatic logic entry_seen(input mms_pkg::mms_state_t st);
        entry_seen = (st != mms_pkg::MMS_ST_IDLE);
    endfunction

    function automatic mms_pkg::mms_mode_t decode_mode(input logic [3:0] n);
        unique case (n)
            mms_pkg::PULSES_CSI: decode_mode = mms_pkg::MMS_MODE_CSI;
            mms_pkg::PULSES_CSI_SHAKE: decode_mode = mms_pkg::MMS_MODE_CSI_SHAKE;
            mms_pkg::PULSES_UART: decode_mode = mms_pkg::MMS_MODE_UART;
            mms_pkg::PULSES_PORT: decode_mode = mms_pkg::MMS_MODE_PORT;
            default: decode_mode = mms_pkg::MMS_MODE_NONE;
        endcase
    endfunction

    // the first rising edge marks entry; the end state holds until reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= mms_pkg::MMS_ST_IDLE;
        end else begin
            unique case (state_reg)
                mms_pkg::MMS_ST_IDLE: begin
                    if (vpp_rise) begin
                        state_reg <= mms_pkg::MMS_ST_COUNT;
                    end
                end
                mms_pkg::MMS_ST_COUNT: begin
                    if (start_s) begin
                        if (decode_mode(pulse_cnt_reg) == mms_pkg::MMS_MODE_NONE) begin
                            state_reg <= mms_pkg::MMS_ST_BAD;
                        end else begin
                            state_reg <= mms_pkg::MMS_ST_DONE;
                        end
                    end
                end
                mms_pkg::MMS_ST_DONE: begin
                end
                mms_pkg::MMS_ST_BAD: begin
                end
            endcase
        end
    end

    // the entry edge is not counted, so a lone entry pulse means zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt_reg <= mms_pkg::PULSES_CSI;
        end else if (state_reg == mms_pkg::MMS_ST_COUNT && !start_s && vpp_rise) begin
            // saturate so a long train cannot wrap onto a valid count
            if (pulse_cnt_reg != mms_pkg::PULSE_COUNT_MAX) begin
                pulse_cnt_reg <= pulse_cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= mms_pkg::MMS_MODE_NONE;
        end else if (state_reg == mms_pkg::MMS_ST_COUNT && start_s) begin
            mode_reg <= decode_mode(pulse_cnt_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode outputs

    // mode is latched until reset; a new entry needs a fresh reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_mode_active <= 1'b0;
        end else begin
            prog_mode_active <= entry_seen(state_reg);
        end
    end

    // from entry on, pins left out of the link keep their reset state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_other_pins_reset <= 1'b0;
        end else begin
            hold_other_pins_reset <= entry_seen(state_reg);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_mode_valid <= 1'b0;
            prog_mode_error <= 1'b0;
        end else begin
            prog_mode_valid <= (state_reg == mms_pkg::MMS_ST_DONE);
            prog_mode_error <= (state_reg == mms_pkg::MMS_ST_BAD);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clocked_serial_channel_en <= 1'b0;
        end else begin
            clocked_serial_channel_en <= (mode_reg == mms_pkg::MMS_MODE_CSI)
                || (mode_reg == mms_pkg::MMS_MODE_CSI_SHAKE);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            handshake_line_en <= 1'b0;
        end else begin
            handshake_line_en <= (mode_reg == mms_pkg::MMS_MODE_CSI_SHAKE);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            async_serial_channel_zero_en <= 1'b0;
        end else begin
            async_serial_channel_zero_en <= (mode_reg == mms_pkg::MMS_MODE_UART);
        end
    end

    // no serial hardware enabled, software drives the port pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_emulated_en <= 1'b0;
        end else begin
            port_emulated_en <= (mode_reg == mms_pkg::MMS_MODE_PORT);
        end
    end

endmodule
`default_nettype wire

//--- testbench/mms_checker.sv
// port-level checks for the map size and mode select block
`timescale 1ns/1ns
`default_nettype none
module mms_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // registers and map
    input wire logic mem_size_wr,
    input wire logic xram_size_wr,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] memory_size_select,
    input wire logic [7:0] expansion_ram_size_select,
    input wire logic [5:0] rom_size_kb,
    input wire logic xram_enable,
    // mode outputs
    input wire logic prog_mode_active,
    input wire logic clocked_serial_channel_en,
    input wire logic handshake_line_en,
    input wire logic async_serial_channel_zero_en,
    input wire logic port_emulated_en,
    input wire logic hold_other_pins_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_reset_values: assert property (
        $rose(rst_n) |-> memory_size_select == 8'hcf && expansion_ram_size_select == 8'h0c)
        else $error("bad register reset value");
    chk_mem_write: assert property (
        mem_size_wr |=> memory_size_select == $past(wr_data))
        else $error("memory size write lost");
    chk_xram_write: assert property (
        xram_size_wr |=> expansion_ram_size_select == $past(wr_data))
        else $error("expansion ram write lost");
    chk_rom_small: assert property (memory_size_select == 8'hc4 |=> rom_size_kb == 6'h10)
        else $error("c4 code not 16 kb");
    chk_rom_full: assert property (memory_size_select == 8'hcf |=> rom_size_kb == 6'h3c)
        else $error("cf code not 60 kb");
    chk_xram_map: assert property (expansion_ram_size_select == 8'h0a |=> xram_enable)
        else $error("0a code maps no ram");
    chk_shake_mode: assert property (
        handshake_line_en |-> clocked_serial_channel_en && !async_serial_channel_zero_en)
        else $error("handshake without clocked serial");
    chk_port_mode: assert property (
        port_emulated_en |-> !clocked_serial_channel_en && !async_serial_channel_zero_en)
        else $error("serial hardware on in port mode");
    chk_pins_held: assert property (hold_other_pins_reset == prog_mode_active)
        else $error("pin hold differs from mode entry");
    chk_hold_latched: assert property (hold_other_pins_reset |=> hold_other_pins_reset)
        else $error("pin hold dropped before reset");
endmodule
bind mms_top mms_checker chk (.clk, .rst_n, .mem_size_wr, .xram_size_wr, .wr_data,
    .memory_size_select, .expansion_ram_size_select, .rom_size_kb, .xram_enable,
    .prog_mode_active, .clocked_serial_channel_en, .handshake_line_en,
    .async_serial_channel_zero_en, .port_emulated_en, .hold_other_pins_reset);
`default_nettype wire

//--- testbench/mms_programmer.sv
// programmer model: voltage pulse train then transfer start
`timescale 1ns/1ns
`default_nettype none
module mms_programmer (
    // pacing clock
    input wire logic clk,
    // pins towards the device, pulled low when idle
    output logic vpp_pin,
    output logic start_pin
);
    // oscillator supplied to the target while writing or erasing, in khz
    localparam int MAIN_OSCILLATOR_FREQUENCY_KHZ = 10000;
    localparam int MAIN_OSCILLATOR_LIMIT_KHZ = 10000;
    initial begin
        vpp_pin = 1'b0;
        start_pin = 1'b0;
    end
    task automatic idle();
        @(negedge clk);
        vpp_pin = 1'b0;
        start_pin = 1'b0;
    endtask
    // entry pulse plus one pulse per count, 3 clk high and low
    task automatic send_mode(input int n);
        for (int i = 0; i <= n; i++) begin
            @(negedge clk);
            vpp_pin = 1'b1;
            repeat (3) @(negedge clk);
            vpp_pin = 1'b0;
            repeat (2) @(negedge clk);
        end
        repeat (4) @(negedge clk);
        start_pin = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- testbench/mms_top_tb.sv
// self-checking bench for the map size and mode select block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module mms_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mem_size_wr = 1'b0;
    logic xram_size_wr = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] memory_size_select, expansion_ram_size_select;
    logic [5:0] rom_size_kb;
    logic [10:0] xram_size_bytes;
    logic xram_enable, prog_mode_active, prog_mode_valid, prog_mode_error;
    logic clocked_serial_channel_en, handshake_line_en, async_serial_channel_zero_en;
    logic port_emulated_en, hold_other_pins_reset, prog_voltage_pin, transfer_start;
    int num_errors = 0;
    int n_tests = 0;
    // 16 extra pulses must saturate at 15, not wrap onto a legal count
    int pulses [6] = '{0, 3, 8, 12, 5, 16};
    // {clocked, handshake, async, port, valid, error}
    logic [5:0] modes [6] = '{6'h22, 6'h32, 6'h0a, 6'h06, 6'h01, 6'h01};
    logic [7:0] codes [5] = '{8'hc4, 8'hc6, 8'hc8, 8'hcc, 8'hcf};
    logic [5:0] sizes [5] = '{6'h10, 6'h18, 6'h20, 6'h30, 6'h3c};
    always #2 clk = ~clk;
    mms_top dut (.clk, .rst_n, .mem_size_wr, .xram_size_wr, .wr_data, .memory_size_select,
        .expansion_ram_size_select, .rom_size_kb, .xram_size_bytes, .xram_enable,
        .prog_voltage_pin, .transfer_start, .prog_mode_active, .prog_mode_valid,
        .prog_mode_error, .clocked_serial_channel_en, .handshake_line_en,
        .async_serial_channel_zero_en, .port_emulated_en, .hold_other_pins_reset);
    mms_programmer prog (.clk, .vpp_pin(prog_voltage_pin), .start_pin(transfer_start));
    task automatic do_reset();
        prog.idle();
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
    endtask
    // one-cycle strobe, returns once the decoded map has settled
    task automatic wr(input logic m, input logic x, input logic [7:0] d);
        @(negedge clk);
        mem_size_wr = m;
        xram_size_wr = x;
        wr_data = d;
        @(negedge clk);
        mem_size_wr = 1'b0;
        xram_size_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        int k;
        do_reset();
        `CHK({memory_size_select, rom_size_kb}, 14'h33fc)
        `CHK({expansion_ram_size_select, xram_enable}, 9'h018)
        `CHK(prog.MAIN_OSCILLATOR_FREQUENCY_KHZ <= prog.MAIN_OSCILLATOR_LIMIT_KHZ, 1'b1)
        for (int i = 0; i < 5; i++) begin
            wr(1'b1, 1'b0, codes[i]);
            `CHK({memory_size_select, rom_size_kb}, {codes[i], sizes[i]})
        end
        wr(1'b0, 1'b1, 8'h0a);
        `CHK({expansion_ram_size_select, xram_enable, xram_size_bytes}, 20'h0ac00)
        wr(1'b1, 1'b1, 8'h0c);
        `CHK({memory_size_select, rom_size_kb, xram_enable}, 15'h0678)
        for (int i = 0; i < 6; i++) begin
            do_reset();
            prog.send_mode(pulses[i]);
            k = 0;
            while ((prog_mode_valid | prog_mode_error) !== 1'b1 && k < 40) begin
                @(negedge clk);
                k++;
            end
            if ((prog_mode_valid | prog_mode_error) !== 1'b1) begin
                num_errors++;
                wrap_up();
            end
            @(negedge clk);
            `CHK({clocked_serial_channel_en, handshake_line_en, async_serial_channel_zero_en,
                port_emulated_en, prog_mode_valid, prog_mode_error}, modes[i])
            `CHK({prog_mode_active, hold_other_pins_reset}, 2'h3)
        end
        wrap_up();
    end
endmodule
`default_nettype wire
